// *** src/clr_pkg.sv ***
// constants and register map of the current-loop receive alarm block
package clr_pkg;
   // clock and timing
   localparam int unsigned CLK_FREQ_MHZ      = 200;
   localparam int unsigned FAULT_TIME_US     = 10000;
   localparam int unsigned FAULT_CYCLES      = FAULT_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned EDGE_STABLE_CYCLES = 4;

   // axi4-lite
   localparam int unsigned ADDR_W = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS      = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS    = 4'h4;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 4'h8;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 4'hc;

   // control fields
   localparam int unsigned CTRL_INVERT_BIT   = 0;
   localparam int unsigned CTRL_RELAY_NC_BIT = 1;
   localparam int unsigned CTRL_CLEAR_BIT    = 2;
   localparam logic [1:0]  CTRL_RESET_VAL    = 2'h0;

   // status fields
   localparam int unsigned STAT_POS_BIT   = 0;
   localparam int unsigned STAT_NEG_BIT   = 1;
   localparam int unsigned STAT_FAULT_BIT = 2;
   localparam int unsigned STAT_QUAL_BIT  = 3;
   localparam int unsigned STAT_ALARM_BIT = 4;
   localparam int unsigned STAT_DATA_BIT  = 5;

   // interrupt events
   localparam int unsigned IRQ_W            = 3;
   localparam int unsigned IRQ_ALARM_SET    = 0;
   localparam int unsigned IRQ_FAULT_START  = 1;
   localparam int unsigned IRQ_ALARM_CLEAR  = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 3'h0;
endpackage : clr_pkg

// *** src/clr_edge_filter.sv ***
// two-stage synchroniser followed by a stability filter for one pin
`timescale 1ns/1ps
module clr_edge_filter
   import clr_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = EDGE_STABLE_CYCLES,
   parameter logic        RESET_LEVEL   = 1'b0
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // pin and cleaned level
   input  wire logic pin_in,
   output logic      level_out
);
   localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

   logic          meta_reg;
   logic          sync_reg;
   logic [CW-1:0] cnt_reg;
   logic          level_reg;
   wire           differs = sync_reg != level_reg;

   // level follows the pin only after it stays changed for STABLE_CYCLES samples
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         meta_reg  <= RESET_LEVEL;
         sync_reg  <= RESET_LEVEL;
         cnt_reg   <= '0;
         level_reg <= RESET_LEVEL;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         if (!differs) begin
            cnt_reg <= '0;
         end else if (cnt_reg == CNT_LAST) begin
            cnt_reg   <= '0;
            level_reg <= sync_reg;
         end else begin
            cnt_reg <= cnt_reg + CW'(1);
         end
      end
   end

   assign level_out = level_reg;
endmodule : clr_edge_filter

// *** src/clr_persist.sv ***
// persistence timer: qualifies a level only after it holds for a number of cycles
`timescale 1ns/1ps
module clr_persist
   import clr_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = FAULT_CYCLES
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // raw and qualified condition
   input  wire logic cond_in,
   output logic      qual_out
);
   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);

   logic [CW-1:0] cnt_reg;
   logic          qual_reg;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cnt_reg  <= '0;
         qual_reg <= 1'b0;
      end else if (!cond_in) begin
         cnt_reg  <= '0;
         qual_reg <= 1'b0;
      end else begin
         if (cnt_reg != CNT_LAST) begin
            cnt_reg <= cnt_reg + CW'(1);
         end
         qual_reg <= cnt_reg == CNT_LAST;
      end
   end

   assign qual_out = qual_reg;
endmodule : clr_persist

// *** src/clr_rx_alarm.sv ***
// receive path, fault alarm and axi4-lite registers of the current-loop line card
`timescale 1ns/1ps
module clr_rx_alarm
   import clr_pkg::*;
#(
   parameter int unsigned FAULT_HOLD_CYCLES = FAULT_CYCLES,
   parameter int unsigned EDGE_CYCLES       = EDGE_STABLE_CYCLES
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              resetn_in,
   // loop direction pins
   input  wire logic              loop_pos_in,
   input  wire logic              loop_neg_in,
   // alarm reset pins
   input  wire logic              local_reset_in,
   input  wire logic              remote_resetn_in,
   // differential data output
   output logic                   data_p_out,
   output logic                   data_n_out,
   // indicators and relay
   output logic                   rx_led_out,
   output logic                   alarm_led_out,
   output logic                   alarm_relay_out,
   // interrupt
   output logic                   irq_out,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   // register address decode, shared by read and write paths
   function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
      decode = {addr == IRQ_MASK_OFS, addr == IRQ_STAT_OFS,
                addr == STATUS_OFS,   addr == CTRL_OFS};
   endfunction : decode

   // cleaned pin levels
   logic pos_dir;
   logic neg_dir;
   logic local_req;
   logic remote_req_n;

   // persistence result
   logic fault_qual;

   // control and status registers
   logic                  invert_reg;
   logic                  relay_nc_reg;
   logic [IRQ_W-1:0]      irq_stat_reg;
   logic [IRQ_W-1:0]      irq_stat_next;
   logic [IRQ_W-1:0]      irq_mask_reg;
   logic                  irq_reg;

   // line state
   logic                  line_data_reg;
   logic                  line_data_next;
   logic                  fault_raw_reg;
   logic                  alarm_reg;
   logic                  alarm_next;

   // output flops
   logic                  data_p_reg;
   logic                  data_n_reg;
   logic                  rx_led_reg;
   logic                  alarm_led_reg;
   logic                  relay_reg;

   // write channel state
   logic                  awready_reg;
   logic                  wready_reg;
   logic                  aw_held_reg;
   logic                  w_held_reg;
   logic [ADDR_W-1:0]     waddr_reg;
   logic [31:0]           wdata_reg;
   logic [3:0]            wstrb_reg;
   logic                  bvalid_reg;
   logic [1:0]            bresp_reg;

   // read channel state
   logic                  arready_reg;
   logic                  rvalid_reg;
   logic [31:0]           rdata_reg;
   logic [1:0]            rresp_reg;

   // direction signals with clean edges
   clr_edge_filter #(
      .STABLE_CYCLES (EDGE_CYCLES),
      .RESET_LEVEL   (1'b0)
   ) u_pos_filter (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .pin_in    (loop_pos_in),
      .level_out (pos_dir)
   );

   clr_edge_filter #(
      .STABLE_CYCLES (EDGE_CYCLES),
      .RESET_LEVEL   (1'b1)   // idle line reads mark, so no false fault after reset
   ) u_neg_filter (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .pin_in    (loop_neg_in),
      .level_out (neg_dir)
   );

   // front-panel and remote reset inputs
   clr_edge_filter #(
      .STABLE_CYCLES (EDGE_CYCLES),
      .RESET_LEVEL   (1'b0)
   ) u_local_filter (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .pin_in    (local_reset_in),
      .level_out (local_req)
   );

   clr_edge_filter #(
      .STABLE_CYCLES (EDGE_CYCLES),
      .RESET_LEVEL   (1'b1)
   ) u_remote_filter (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .pin_in    (remote_resetn_in),
      .level_out (remote_req_n)
   );

   // fault is the equality of the two direction signals
   wire fault_raw = ~(pos_dir ^ neg_dir);

   clr_persist #(
      .HOLD_CYCLES (FAULT_HOLD_CYCLES)
   ) u_persist (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .cond_in   (fault_raw),
      .qual_out  (fault_qual)
   );

   // bus handshakes and decode
   wire       aw_hs     = s_axi_awvalid & awready_reg;
   wire       w_hs      = s_axi_wvalid & wready_reg;
   wire       ar_hs     = s_axi_arvalid & arready_reg;
   wire       b_hs      = bvalid_reg & s_axi_bready;
   wire       r_hs      = rvalid_reg & s_axi_rready;
   wire       wr_fire   = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire [3:0] wr_sel    = decode(waddr_reg);
   wire [3:0] rd_sel    = decode(s_axi_araddr);
   wire       wr_low    = wr_fire & wstrb_reg[0];
   wire       ctrl_wr   = wr_low & wr_sel[0];
   wire       stat_w1c  = wr_low & wr_sel[2];
   wire       mask_wr   = wr_low & wr_sel[3];
   wire       sw_clear  = ctrl_wr & wdata_reg[CTRL_CLEAR_BIT];

   // merged data: a valid line state updates it, a fault holds the last one
   assign line_data_next = fault_raw ? line_data_reg : pos_dir;

   // alarm latch: a qualified fault always wins over any reset request
   wire remote_req = ~remote_req_n;
   wire clear_req  = local_req | remote_req | sw_clear;
   assign alarm_next = fault_qual | (alarm_reg & ~clear_req);

   // interrupt events, a new event wins over a write-one-to-clear
   wire [IRQ_W-1:0] irq_event;
   assign irq_event[IRQ_ALARM_SET]   = alarm_next & ~alarm_reg;
   assign irq_event[IRQ_FAULT_START] = fault_raw & ~fault_raw_reg;
   assign irq_event[IRQ_ALARM_CLEAR] = alarm_reg & ~alarm_next;
   wire [IRQ_W-1:0] irq_clear = stat_w1c ? wdata_reg[IRQ_W-1:0] : '0;
   assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_event;
   wire [IRQ_W-1:0] irq_pending = irq_stat_reg & irq_mask_reg;

   // read selects
   wire rd_ctrl   = rd_sel[0];
   wire rd_status = rd_sel[1];
   wire rd_istat  = rd_sel[2];
   wire rd_imask  = rd_sel[3];

   // read data selection
   wire [31:0] ctrl_rd = {30'h0, relay_nc_reg, invert_reg};
   wire [31:0] stat_rd = {26'h0, line_data_reg, alarm_reg, fault_qual,
                          fault_raw, neg_dir, pos_dir};
   wire [31:0] rd_mux  = rd_ctrl   ? ctrl_rd :
                         rd_status ? stat_rd :
                         rd_istat  ? {29'h0, irq_stat_reg} :
                         rd_imask  ? {29'h0, irq_mask_reg} : 32'h0;
   wire [1:0]  rd_resp = |rd_sel ? RESP_OKAY : RESP_SLVERR;
   wire [1:0]  wr_resp = |wr_sel ? RESP_OKAY : RESP_SLVERR;

   // output drive levels
   wire drive_p   = line_data_next ^ invert_reg;
   wire relay_lvl = alarm_next ^ relay_nc_reg;

   // line state and outputs
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         line_data_reg <= 1'b0;
         fault_raw_reg <= 1'b0;
         alarm_reg     <= 1'b0;
         data_p_reg    <= 1'b0;
         data_n_reg    <= 1'b1;
         rx_led_reg    <= 1'b0;
         alarm_led_reg <= 1'b0;
         relay_reg     <= 1'b0;
      end else begin
         line_data_reg <= line_data_next;
         fault_raw_reg <= fault_raw;
         alarm_reg     <= alarm_next;
         data_p_reg    <= drive_p;
         data_n_reg    <= ~drive_p;
         rx_led_reg    <= line_data_next;
         alarm_led_reg <= alarm_next;
         relay_reg     <= relay_lvl;
      end
   end

   // software registers and interrupt
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         invert_reg   <= CTRL_RESET_VAL[CTRL_INVERT_BIT];
         relay_nc_reg <= CTRL_RESET_VAL[CTRL_RELAY_NC_BIT];
         irq_stat_reg <= IRQ_RESET_VAL;
         irq_mask_reg <= IRQ_RESET_VAL;
         irq_reg      <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            invert_reg   <= wdata_reg[CTRL_INVERT_BIT];
            relay_nc_reg <= wdata_reg[CTRL_RELAY_NC_BIT];
         end
         if (mask_wr) begin
            irq_mask_reg <= wdata_reg[IRQ_W-1:0];
         end
         irq_stat_reg <= irq_stat_next;
         irq_reg      <= |irq_pending;
      end
   end

   // axi4-lite write channels, address and data taken in either order
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         waddr_reg   <= '0;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            waddr_reg   <= s_axi_awaddr;
         end
         if (w_hs) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_resp;
         end
         if (b_hs) begin
            bvalid_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // axi4-lite read channels
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_mux;
         rresp_reg   <= rd_resp;
      end else if (r_hs) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // port drive
   assign data_p_out      = data_p_reg;
   assign data_n_out      = data_n_reg;
   assign rx_led_out      = rx_led_reg;
   assign alarm_led_out   = alarm_led_reg;
   assign alarm_relay_out = relay_reg;
   assign irq_out         = irq_reg;
   assign s_axi_awready   = awready_reg;
   assign s_axi_wready    = wready_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = arready_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
endmodule : clr_rx_alarm

// *** sim/clr_rx_alarm_sva.sv ***
// assertion checker bound to the current-loop receive alarm block
`timescale 1ns/1ps
module clr_rx_alarm_sva
   import clr_pkg::*;
#(
   parameter int unsigned FAULT_HOLD_CYCLES = FAULT_CYCLES,
   parameter int unsigned EDGE_CYCLES       = EDGE_STABLE_CYCLES
) (
   // clock, reset and loop pins
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        loop_pos_in,
   input wire logic        loop_neg_in,
   // line and alarm outputs
   input wire logic        rx_led_out,
   input wire logic        data_p_out,
   input wire logic        data_n_out,
   input wire logic        alarm_led_out,
   input wire logic        alarm_relay_out,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   // consecutive cycles with both direction pins at the same level
   logic [31:0] eq_cnt_reg;
   always_ff @(posedge clk_in) begin
      if (!resetn_in || loop_pos_in != loop_neg_in) begin
         eq_cnt_reg <= 32'h0;
      end else if (eq_cnt_reg != 32'hffffffff) begin
         eq_cnt_reg <= eq_cnt_reg + 32'h1;
      end
   end

   a_space_led: assert property ((loop_pos_in && !loop_neg_in) [*8] |-> ##2 rx_led_out)
      else $error("rx led dark while line shows space");
   a_mark_led: assert property ((!loop_pos_in && loop_neg_in) [*8] |-> ##2 !rx_led_out)
      else $error("rx led lit while line shows mark");
   a_diff_pair: assert property (data_n_out != data_p_out)
      else $error("data outputs not complementary");
   a_alarm_early: assert property ($rose(alarm_led_out) |-> eq_cnt_reg >= FAULT_HOLD_CYCLES)
      else $error("alarm raised before fault persisted");
   a_alarm_late: assert property (eq_cnt_reg >= FAULT_HOLD_CYCLES + 16 |-> alarm_led_out)
      else $error("alarm missing during persistent fault");
   a_alarm_fall: assert property ($fell(alarm_led_out) |->
      eq_cnt_reg < FAULT_HOLD_CYCLES + EDGE_CYCLES + 3)
      else $error("alarm cleared while fault still qualified");
   a_relay_follow: assert property ($changed(alarm_led_out) |-> $changed(alarm_relay_out))
      else $error("relay did not follow alarm");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule : clr_rx_alarm_sva

bind clr_rx_alarm clr_rx_alarm_sva #(
   .FAULT_HOLD_CYCLES(FAULT_HOLD_CYCLES), .EDGE_CYCLES(EDGE_CYCLES)
) i_sva (
   .clk_in(clk_in), .resetn_in(resetn_in), .loop_pos_in(loop_pos_in), .loop_neg_in(loop_neg_in),
   .rx_led_out(rx_led_out), .data_p_out(data_p_out), .data_n_out(data_n_out),
   .alarm_led_out(alarm_led_out), .alarm_relay_out(alarm_relay_out),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// *** sim/clr_loop_tx.sv ***
// remote current-loop transmitter and remote reset contact model
`timescale 1ns/1ps
module clr_loop_tx (
   // line control
   input  wire logic       space_in,
   input  wire logic [1:0] mode_in,
   input  wire logic       close_in,
   // pins seen by the receiver
   output logic            loop_pos_out,
   output logic            loop_neg_out,
   output logic            remote_resetn_out
);
   // mode 0 sends data, 1 open line (no current), 2 failed transmitter (both levels)
   assign loop_pos_out      = (mode_in == 2'h0) ? space_in : (mode_in == 2'h2);
   assign loop_neg_out      = (mode_in == 2'h0) ? !space_in : (mode_in == 2'h2);
   // contact closure pulls the input to ground, otherwise pulled up
   assign remote_resetn_out = !close_in;
endmodule : clr_loop_tx

// *** sim/tb_clr_rx_alarm.sv ***
// self-checking testbench of the current-loop receive alarm block
`timescale 1ns/1ps
module tb_clr_rx_alarm
   import clr_pkg::*;
;
   localparam int unsigned HOLD = 20;
   logic clk_in = 1'b0, resetn_in = 1'b0, local_reset_in = 1'b0, space = 1'b0, close = 1'b0;
   logic [1:0] mode = 2'h0;
   logic loop_pos_in, loop_neg_in, remote_resetn_in, data_p_out, data_n_out;
   logic rx_led_out, alarm_led_out, alarm_relay_out, irq_out;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int fails = 0, n_compared = 0;

   always #2.5 clk_in = ~clk_in;

   clr_loop_tx i_far (.space_in(space), .mode_in(mode), .close_in(close),
      .loop_pos_out(loop_pos_in), .loop_neg_out(loop_neg_in), .remote_resetn_out(remote_resetn_in));

   clr_rx_alarm #(.FAULT_HOLD_CYCLES(HOLD), .EDGE_CYCLES(2)) i_dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .loop_pos_in(loop_pos_in), .loop_neg_in(loop_neg_in),
      .local_reset_in(local_reset_in), .remote_resetn_in(remote_resetn_in),
      .data_p_out(data_p_out), .data_n_out(data_n_out), .rx_led_out(rx_led_out),
      .alarm_led_out(alarm_led_out), .alarm_relay_out(alarm_relay_out), .irq_out(irq_out),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cycles

   task automatic wait_alarm(input logic exp);
      int n;
      n = 0;
      while (alarm_led_out !== exp && n < HOLD + 40) begin
         @(posedge clk_in);
         n++;
      end
      chk1(alarm_led_out, exp);
   endtask : wait_alarm

   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, RESP_OKAY);
   endtask : axi_write

   task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axi_read

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      chk(d, exp);
      chk(r, RESP_OKAY);
   endtask : rd_chk

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(CTRL_OFS, 32'h0);
      rd_chk(STATUS_OFS, 32'h2);
      rd_chk(IRQ_MASK_OFS, 32'h0);
      axi_write(IRQ_MASK_OFS, 32'h5);
      rd_chk(IRQ_MASK_OFS, 32'h5);
      axi_write(IRQ_MASK_OFS, 32'h0);
      axi_write(CTRL_OFS, 32'h4);
      rd_chk(CTRL_OFS, 32'h0);
      axi_read(4'h6, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_polarity();
      for (int i = 0; i < 4; i++) begin
         axi_write(CTRL_OFS, {31'h0, i[1]});
         @(posedge clk_in);
         space <= i[0];
         cycles(12);
         chk1(rx_led_out, i[0]);
         chk1(data_p_out, i[0] ^ i[1]);
         chk1(data_n_out, !(i[0] ^ i[1]));
         chk1(alarm_led_out, 1'b0);
      end
      $display("test polarity done");
   endtask : t_polarity

   task automatic t_short_fault();
      repeat (2) begin
         @(posedge clk_in);
         mode <= 2'h2;
         cycles(HOLD - 4);
         @(posedge clk_in);
         mode <= 2'h0;
         cycles(10);
      end
      chk1(alarm_led_out, 1'b0);
      $display("test short fault done");
   endtask : t_short_fault

   task automatic t_alarm();
      axi_write(IRQ_STAT_OFS, 32'h7);
      rd_chk(IRQ_STAT_OFS, 32'h0);
      @(posedge clk_in);
      mode <= 2'h2;
      wait_alarm(1'b1);
      chk1(alarm_relay_out, 1'b1);
      rd_chk(STATUS_OFS, 32'h3f);
      chk1(irq_out, 1'b0);
      axi_write(IRQ_MASK_OFS, 32'h7);
      cycles(2);
      chk1(irq_out, 1'b1);
      @(posedge clk_in);
      local_reset_in <= 1'b1;
      cycles(10);
      chk1(alarm_led_out, 1'b1);
      local_reset_in <= 1'b0;
      mode <= 2'h0;
      cycles(12);
      chk1(alarm_led_out, 1'b1);
      local_reset_in <= 1'b1;
      wait_alarm(1'b0);
      @(posedge clk_in);
      local_reset_in <= 1'b0;
      rd_chk(IRQ_STAT_OFS, 32'h7);
      axi_write(IRQ_STAT_OFS, 32'h7);
      cycles(2);
      chk1(irq_out, 1'b0);
      rd_chk(IRQ_STAT_OFS, 32'h0);
      $display("test alarm done");
   endtask : t_alarm

   task automatic t_relay();
      axi_write(CTRL_OFS, 32'h2);
      cycles(2);
      chk1(alarm_relay_out, 1'b1);
      mode <= 2'h1;
      wait_alarm(1'b1);
      chk1(alarm_relay_out, 1'b0);
      mode <= 2'h0;
      cycles(12);
      close <= 1'b1;
      wait_alarm(1'b0);
      chk1(alarm_relay_out, 1'b1);
      close <= 1'b0;
      cycles(8);
      mode <= 2'h1;
      wait_alarm(1'b1);
      mode <= 2'h0;
      cycles(12);
      axi_write(CTRL_OFS, 32'h6);
      wait_alarm(1'b0);
      axi_write(CTRL_OFS, 32'h0);
      $display("test relay done");
   endtask : t_relay

   // whole run needs a few hundred cycles; allow about a hundred times that
   initial begin
      #200000;
      fails++;
      print_verdict();
   end

   initial begin
      cycles(12);
      resetn_in <= 1'b1;
      cycles(8);
      t_regs();
      t_polarity();
      t_short_fault();
      t_alarm();
      t_relay();
      print_verdict();
   end
endmodule : tb_clr_rx_alarm
